//--- shared/mps_pkg.sv
// package of constants and types for the program sequencer
package mps_pkg;
    localparam int PC_W    = 13;                // program counter width
    localparam int STK_DEPTH = 8;               // return stack levels
    localparam int SP_W    = 3;                 // stack index width; pointer is one bit wider
    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;  // run control
    localparam logic [7:0] OFS_PCLOW  = 8'h04;  // pc low byte
    localparam logic [7:0] OFS_STATUS = 8'h08;  // sequencer status
    localparam logic [7:0] OFS_IRQ    = 8'h0c;  // interrupt request/enable
    localparam logic [7:0] OFS_ALU    = 8'h10;  // alu operand/op
    localparam logic [7:0] OFS_ACC    = 8'h14;  // accumulator and alu status
    // fixed vectors
    localparam logic [12:0] VEC_RESET = 13'h0000;
    localparam logic [12:0] VEC_EXT   = 13'h0004;
    localparam logic [12:0] VEC_TMR0  = 13'h0008;
    localparam logic [12:0] VEC_STEP  = 13'h0004;
    localparam logic [12:0] VEC_ADC   = 13'h0018;
    // reset values and phase codes
    localparam logic [7:0] RST_ACC    = 8'h00;
    localparam logic [3:0] RST_FLAGS  = 4'h0;
    localparam logic [1:0] PH_T1      = 2'h0;
    localparam logic [1:0] PH_T4      = 2'h3;
    // instruction classes, bits 15:13 of the program word
    localparam logic [2:0] CL_ALU  = 3'h0;      // alu op with [7:0] operand
    localparam logic [2:0] CL_JMP  = 3'h1;      // unconditional_branch
    localparam logic [2:0] CL_CALL = 3'h2;      // subroutine call
    localparam logic [2:0] CL_RET  = 3'h3;      // subroutine_return
    localparam logic [2:0] CL_INTERRUPT_RETURN = 3'h4;      // interrupt_return
    localparam logic [2:0] CL_SZ   = 3'h5;      // skip if alu result zero
    localparam logic [2:0] CL_PCL  = 3'h6;      // load pc_low_byte
    localparam logic [2:0] CL_NOP  = 3'h7;      // no operation
    // alu operation codes
    typedef enum logic [3:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR, ALU_XOR,
        ALU_CPL, ALU_RL, ALU_RLC, ALU_RR, ALU_RRC, ALU_INC, ALU_DEC, ALU_MOV
    } mps_alu_op_e;
endpackage : mps_pkg

//--- design/mps_stack.sv
// eight-level return stack memory with registered read data
`timescale 1ns/1ps
module mps_stack
    import mps_pkg::*;
#(
    parameter int DEPTH = STK_DEPTH,     // levels
    parameter int AW    = SP_W           // index width
)(
    input  wire logic          clk,      // system clock
    input  wire logic          wr_en,    // write strobe
    input  wire logic [AW-1:0] wr_idx,   // write index
    input  wire logic [PC_W-1:0] wr_data, // pushed pc
    input  wire logic [AW-1:0] rd_idx,   // read index
    output logic [PC_W-1:0]    rd_data   // registered top entry
);
    initial
    begin
        if (DEPTH != (1 << AW)) $error("stack depth must be 2**aw");
    end
    logic [PC_W-1:0] mem_r [DEPTH];      // storage, not software visible
    // write port
    always_ff @(posedge clk)
    begin
        if (wr_en) mem_r[wr_idx] <= wr_data;
    end
    // registered read port
    always_ff @(posedge clk)
    begin
        rd_data <= mem_r[rd_idx];
    end
endmodule : mps_stack

//--- design/mps_alu.sv
// eight-bit alu with carry, aux carry and overflow; zero is derived by the sequencer
`timescale 1ns/1ps
module mps_alu
    import mps_pkg::*;
(
    input  wire logic [3:0] op,          // operation code
    input  wire logic [7:0] a,           // accumulator operand
    input  wire logic [7:0] b,           // second operand
    input  wire logic       cin,         // carry in
    input  wire logic       acin,        // aux carry in
    output logic [7:0]      y,           // result
    output logic            cout,        // carry / not borrow
    output logic            ac,          // auxiliary carry
    output logic            ov           // signed overflow
);
    logic [8:0] s;                       // wide sum
    logic [4:0] h;                       // nibble sum
    logic [7:0] bb;                      // add operand
    logic       ci;                      // effective carry in
    logic       arith;                   // op sets overflow
    // combinational operation select
    always_comb
    begin
        bb = b;
        ci = 1'b0;
        arith = 1'b0;
        s = 9'h000;
        h = 5'h00;
        y = a;
        cout = cin;
        ac = 1'b0;
        ov = 1'b0;
        case (mps_alu_op_e'(op))
            ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC:
            begin
                bb = (op == ALU_SUB || op == ALU_SBC) ? ~b : b;
                ci = (op == ALU_ADD) ? 1'b0 : (op == ALU_SUB) ? 1'b1 : cin;
                arith = 1'b1;
            end
            default: ;
        endcase
        s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        case (mps_alu_op_e'(op))
            ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC:
            begin
                y = s[7:0];
                cout = s[8];
                ac = h[4];
                ov = arith & (a[7] == bb[7]) & (s[7] != a[7]);
            end
            ALU_DAA:
            begin
                // decimal_adjust: add six per nibble above nine
                s = {1'b0, a} + ((a[3:0] > 4'h9 || acin) ? 9'h006 : 9'h000);
                s = s + ((s[7:4] > 4'h9 || s[8] || cin) ? 9'h060 : 9'h000);
                y = s[7:0];
                cout = s[8] | cin;
            end
            ALU_AND: y = a & b;
            ALU_OR:  y = a | b;
            ALU_XOR: y = a ^ b;
            ALU_CPL: y = ~b;
            ALU_RL:  y = {b[6:0], b[7]};
            ALU_RLC:
            begin
                y = {b[6:0], cin};
                cout = b[7];
            end
            ALU_RR:  y = {b[0], b[7:1]};
            ALU_RRC:
            begin
                y = {cin, b[7:1]};
                cout = b[0];
            end
            ALU_INC: y = b + 8'h01;
            ALU_DEC: y = b - 8'h01;
            ALU_MOV: y = b;
            default: y = a;
        endcase
    end
endmodule : mps_alu

//--- design/mps_sequencer.sv
// program sequencer: four-phase cycle, pipeline, pc, return stack, alu
// Notes on behaviour
// RL1: four phases make one instruction cycle
// RL2: pc advances at phase one during fetch
// RL3: fetch overlaps execute; branches flush, add cycle
// RL4: rc mode pin outputs one-to-three phase clock
// RL5: pc increments by one otherwise
// RL6: taken skip replaces next instruction with dummy
// RL7: low byte write keeps upper pc bits
// RL8: jump/call load address; returns load stack top
// RL9: eight-entry stack hidden from software
// RL10: call/interrupt push; returns pop
// RL11: reset leaves stack empty
// RL12: full stack holds interrupt until return
// RL13: call on full stack still executes
// RL14: alu result to target, status updated
// RL15: add sub daa logic rotate inc dec
// RL16: data moves through accumulator and alu
// RL17: vectors zero, 004 to 014, 018
// RL18: vector entry times like a call
`timescale 1ns/1ps
module mps_sequencer
    import mps_pkg::*;
(
    input  wire logic        clk,              // system clock, 100 mhz
    input  wire logic        rst_b,            // synchronous reset, active low
    input  wire logic        psel,             // apb select
    input  wire logic        penable,          // apb enable
    input  wire logic        pwrite,           // apb direction
    input  wire logic [7:0]  paddr,            // apb byte address
    input  wire logic [31:0] pwdata,           // apb write data
    output logic [31:0]      prdata,           // apb read data
    output logic             pready,           // apb ready
    output logic             pslverr,          // apb error
    output logic [PC_W-1:0]  pmem_addr,        // program memory address
    input  wire logic [15:0] pmem_data,        // program word, valid at phase two
    input  wire logic [5:0]  irq_src,          // ext, timer0..3, adc requests
    input  wire logic        rc_mode,          // rc oscillator selected
    output logic             second_oscillator_pin, // phase-one sync clock
    output logic [1:0]       phase             // instruction_cycle_phases index
);
    // phase counter and pipeline state
    logic [1:0]      phase_r;                  // current phase
    logic [PC_W-1:0] pc_r;                     // program counter
    logic [PC_W-1:0] pc_nxt;                   // next counter value
    logic [15:0]     ir_r;                     // prefetched instruction
    logic            ir_valid_r;               // prefetch holds a real instruction
    logic [SP_W:0]   sp_r;                     // return_stack_pointer, count
    logic            run_r;                    // software run enable
    logic [5:0]      irq_flag_r;               // latched interrupt requests
    logic [5:0]      irq_en_r;                 // interrupt enables
    logic            gie_r;                    // global interrupt enable
    logic [7:0]      acc_r;                    // accumulator
    logic [3:0]      flags_r;                  // c, ac, z, ov
    logic [7:0]      alu_b_r;                  // software alu operand
    logic [3:0]      alu_op_r;                 // software alu op
    logic [PC_W-1:0] stk_top;                  // registered stack top
    logic [7:0]      alu_y;                    // alu result
    logic            alu_c;                    // alu carry
    logic            alu_ac;                   // alu aux carry
    logic            alu_ov;                   // alu overflow
    logic [5:0]      irq_s1_r;                 // sync stage one
    logic [5:0]      irq_s2_r;                 // sync stage two
    logic [5:0]      irq_s3_r;                 // sync stage three
    logic [5:0]      irq_lvl_r;                // agreed level
    logic            pcl_wr_pend_r;            // software pcl write waiting

    // phase boundary strobes
    wire             t1        = (phase_r == PH_T1);
    wire             t4        = (phase_r == PH_T4);
    wire [2:0]       cls       = ir_r[15:13];
    wire             stk_full  = (sp_r == (SP_W+1)'(STK_DEPTH));
    wire             stk_empty = (sp_r == '0);
    // pending interrupt choice, lowest index wins
    wire [5:0]       irq_live  = irq_flag_r & irq_en_r;
    wire             irq_take  = gie_r & (|irq_live) & ~stk_full & run_r; // RL12
    // instruction decode
    wire             ex        = ir_valid_r & run_r;
    wire             do_alu    = ex & (cls == CL_ALU);
    wire             do_jmp    = ex & (cls == CL_JMP);
    wire             do_call   = ex & (cls == CL_CALL);
    wire             do_ret    = ex & (cls == CL_RET) & ~stk_empty;
    wire             do_interrupt_return   = ex & (cls == CL_INTERRUPT_RETURN) & ~stk_empty;
    wire             do_skip   = ex & (cls == CL_SZ) & (alu_y == 8'h00); // RL6
    wire             do_pcl    = ex & (cls == CL_PCL);
    wire             push      = t4 & (do_call | (irq_take & ~(do_ret | do_interrupt_return))); // RL10
    wire             pop       = t4 & (do_ret | do_interrupt_return);  // RL10
    wire             redirect  = do_jmp | do_call | do_ret | do_interrupt_return | do_skip
                                 | do_pcl | pcl_wr_pend_r | irq_take; // RL3
    wire [SP_W-1:0]  wr_idx    = sp_r[SP_W-1:0];
    wire [SP_W-1:0]  rd_idx    = SP_W'(sp_r - 1'b1);
    // apb decode
    wire             apb_wr    = psel & penable & pwrite;
    wire             apb_rd    = psel & ~pwrite;
    wire             hit       = (paddr == OFS_CTRL) | (paddr == OFS_PCLOW)
                                 | (paddr == OFS_STATUS) | (paddr == OFS_IRQ)
                                 | (paddr == OFS_ALU) | (paddr == OFS_ACC);
    wire             ir_alu    = t4 & ex & ((cls == CL_ALU) | (cls == CL_SZ));
    wire             sw_alu    = apb_wr & (paddr == OFS_ALU);
    wire [3:0]       op_sel    = ir_alu ? ir_r[11:8] : sw_alu ? pwdata[11:8] : alu_op_r;
    wire [7:0]       b_sel     = ir_alu ? ir_r[7:0] : sw_alu ? pwdata[7:0] : alu_b_r;

    // vector of the highest priority request
    function automatic logic [PC_W-1:0] vec_of(input logic [5:0] live);
        logic [PC_W-1:0] v;
        v = VEC_ADC;
        for (int i = 4; i >= 0; i--)
        begin
            if (live[i]) v = (i == 0) ? VEC_EXT : PC_W'(VEC_TMR0 + VEC_STEP * (i - 1));
        end
        return v;                                  // RL17
    endfunction : vec_of

    mps_alu u_alu (
        .op   (op_sel),
        .a    (acc_r),
        .b    (b_sel),
        .cin  (flags_r[0]),
        .acin (flags_r[1]),
        .y    (alu_y),
        .cout (alu_c),
        .ac   (alu_ac),
        .ov   (alu_ov)
    );

    mps_stack u_stack (
        .clk     (clk),
        .wr_en   (push & ~stk_full),
        .wr_idx  (wr_idx),
        .wr_data (pc_r),
        .rd_idx  (rd_idx),
        .rd_data (stk_top)
    );

    // next program counter, computed for the phase-four update
    always_comb
    begin
        pc_nxt = PC_W'(pc_r + 1'b1);               // RL5
        if (do_ret | do_interrupt_return)
            pc_nxt = stk_top;                      // RL8
        else if (irq_take)
            pc_nxt = vec_of(irq_live);             // RL18
        else if (pcl_wr_pend_r)
            pc_nxt = {pc_r[12:8], alu_b_r};        // RL7
        else if (do_jmp | do_call)
            pc_nxt = ir_r[12:0];                   // RL8
        else if (do_pcl)
            pc_nxt = {pc_r[12:8], acc_r};          // RL7
    end

    // phase counter, one full turn per instruction cycle
    always_ff @(posedge clk)
    begin
        if (!rst_b) phase_r <= PH_T1;
        else        phase_r <= phase_r + 2'h1;     // RL1
    end

    // pc and prefetch register
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pc_r       <= VEC_RESET;               // RL17
            ir_r       <= 16'hffff;
            ir_valid_r <= 1'b0;
        end
        else if (t4 & run_r)
        begin
            pc_r       <= redirect ? pc_nxt : PC_W'(pc_r + 1'b1); // RL2
            ir_r       <= pmem_data;               // RL3
            ir_valid_r <= ~redirect;               // RL3
        end
    end

    // stack pointer: push/pop counts; reset empties
    always_ff @(posedge clk)
    begin
        if (!rst_b)      sp_r <= '0;               // RL11
        else if (push)   sp_r <= stk_full ? sp_r : sp_r + 1'b1; // RL13
        else if (pop)    sp_r <= sp_r - 1'b1;
    end

    // three-stage synchroniser on interrupt pins
    always_ff @(posedge clk)
    begin
        irq_s1_r  <= irq_src;
        irq_s2_r  <= irq_s1_r;
        irq_s3_r  <= irq_s2_r;
        if (!rst_b)                  irq_lvl_r <= '0;
        else if (irq_s2_r == irq_s3_r) irq_lvl_r <= irq_s3_r;
    end

    // request flags: rising request sets, acknowledge or software clears
    logic [5:0] irq_prev_r;                        // previous agreed level
    wire  [5:0] irq_rise = irq_lvl_r & ~irq_prev_r;
    wire  [5:0] irq_ack  = (push & irq_take & ~do_call) ?
                           (irq_live & ~(irq_live - 6'h01)) : 6'h00;
    wire  [5:0] sw_clr   = (apb_wr & paddr == OFS_IRQ) ? pwdata[13:8] : 6'h00;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            irq_prev_r <= '0;
            irq_flag_r <= '0;
        end
        else
        begin
            irq_prev_r <= irq_lvl_r;
            irq_flag_r <= (irq_flag_r & ~irq_ack & ~sw_clr) | irq_rise; // RL12
        end
    end

    // accumulator and status from alu; accumulator also loaded by apb write to OFS_ACC
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            acc_r   <= RST_ACC;
            flags_r <= RST_FLAGS;
        end
        else if ((t4 & do_alu) | (sw_alu & pwdata[31]))
        begin
            acc_r   <= alu_y;                      // RL16
            flags_r <= {alu_ov, alu_y == 8'h00, alu_ac, alu_c}; // RL14 RL15
        end
        else if (apb_wr & paddr == OFS_ACC)
            acc_r   <= pwdata[7:0];
    end

    // software registers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            run_r         <= 1'b0;
            gie_r         <= 1'b0;
            irq_en_r      <= '0;
            alu_b_r       <= 8'h00;
            alu_op_r      <= 4'h0;
            pcl_wr_pend_r <= 1'b0;
        end
        else
        begin
            if (apb_wr & paddr == OFS_CTRL) run_r <= pwdata[0];
            if (apb_wr & paddr == OFS_IRQ)
            begin
                irq_en_r <= pwdata[5:0];
                gie_r    <= pwdata[7];
            end
            else if (pop & do_interrupt_return) gie_r <= 1'b1;
            else if (push & irq_take & ~do_call) gie_r <= 1'b0;
            if (sw_alu)
            begin
                alu_b_r  <= pwdata[7:0];
                alu_op_r <= pwdata[11:8];
            end
            if (apb_wr & paddr == OFS_PCLOW)
            begin
                alu_b_r       <= pwdata[7:0];
                pcl_wr_pend_r <= 1'b1;             // RL7
            end
            else if (t4 & run_r) pcl_wr_pend_r <= 1'b0;
        end
    end

    // apb read mux, stack never visible
    always_ff @(posedge clk)
    begin
        if (!rst_b) prdata <= 32'h0000_0000;
        else if (apb_rd & ~penable)
        begin
            case (paddr)
                OFS_CTRL:   prdata <= {31'h0, run_r};
                OFS_PCLOW:  prdata <= {24'h0, pc_r[7:0]};
                OFS_STATUS: prdata <= {16'h0, 3'h0, pc_r};   // RL9
                OFS_IRQ:    prdata <= {18'h0, irq_flag_r, gie_r, 1'b0, irq_en_r};
                OFS_ALU:    prdata <= {20'h0, alu_op_r, alu_b_r};
                OFS_ACC:    prdata <= {20'h0, flags_r, acc_r};
                default:    prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~hit;
    assign pmem_addr = pc_r;
    assign phase     = phase_r;
    // phase-one sync clock, high one phase in four
    assign second_oscillator_pin = rc_mode & t1; // RL4
endmodule : mps_sequencer

//--- tb/mps_sequencer_sva.sv
// port-level assertions for the program sequencer
`timescale 1ns/1ps
module mps_sequencer_sva
    import mps_pkg::*;
(
    input wire logic            clk,       // system clock
    input wire logic            rst_b,     // reset, low
    input wire logic            psel,      // apb select
    input wire logic            penable,   // apb enable
    input wire logic [7:0]      paddr,     // apb byte address
    input wire logic [31:0]     prdata,    // apb read data
    input wire logic            pready,    // apb ready
    input wire logic            pslverr,   // apb error
    input wire logic [PC_W-1:0] pmem_addr, // fetch address
    input wire logic            rc_mode,   // rc mode
    input wire logic            second_oscillator_pin, // phase-one sync
    input wire logic [1:0]      phase      // phase index
);
    // decode of mapped offsets
    wire logic hit = paddr inside {OFS_CTRL, OFS_PCLOW, OFS_STATUS, OFS_IRQ, OFS_ALU, OFS_ACC};
    wire logic setup_ph = psel && !penable; // setup cycle of a transfer
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // pin low three phases
    sequence s_pin_low;
        !second_oscillator_pin [*3];
    endsequence
    // rc mode for one cycle
    sequence s_rc_cycle;
        rc_mode [*4];
    endsequence
    chk_phase_step: assert property ($changed(phase) |-> phase == $past(phase) + 2'h1)
        else $error("phase skipped");
    chk_pc_at_t1: assert property ($changed(pmem_addr) |-> phase == PH_T1 && $past(phase) == PH_T4)
        else $error("pc moved off t1");
    chk_fetch_hold: assert property ($changed(pmem_addr) |=> $stable(pmem_addr) [*3])
        else $error("fetch held short");
    chk_pin_equ: assert property (second_oscillator_pin == (rc_mode && phase == PH_T1))
        else $error("sync pin wrong");
    chk_pin_low: assert property ($fell(second_oscillator_pin) |-> s_pin_low)
        else $error("sync pin low time wrong");
    chk_pin_period: assert property ($rose(second_oscillator_pin) ##0 s_rc_cycle |=> second_oscillator_pin)
        else $error("sync pin period");
    chk_reset_vec: assert property ($rose(rst_b) |-> phase == PH_T1 && pmem_addr == VEC_RESET)
        else $error("reset state wrong");
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_err_decode: assert property (psel && penable |-> pslverr == !hit)
        else $error("pslverr decode wrong");
    chk_rdata_hold: assert property ($changed(prdata) |-> $past(setup_ph))
        else $error("prdata moved");
endmodule : mps_sequencer_sva
bind mps_sequencer mps_sequencer_sva u_sva (.*);

//--- tb/mps_pmem_model.sv
// program memory and interrupt source model facing the sequencer
`timescale 1ns/1ps
module mps_pmem_model
    import mps_pkg::*;
(
    input  wire logic            clk,       // system clock
    input  wire logic [PC_W-1:0] pmem_addr, // fetch address
    output logic [15:0]          pmem_data, // program word
    input  wire logic [5:0]      irq_req,   // bench request levels
    output logic [5:0]           irq_src    // request lines to the core
);
    logic [15:0] mem [2**PC_W]; // program words, no-op by default
    // combinational read
    assign pmem_data = mem[pmem_addr];
    // requests move after an edge
    always_ff @(posedge clk)
    begin
        irq_src <= irq_req;
    end
    // fill with no-ops
    initial
    begin
        foreach (mem[i])
            mem[i] = 16'he000;
    end
endmodule : mps_pmem_model

//--- tb/test_mcu_program_sequencer.sv
// self-checking bench for the program sequencer
`timescale 1ns/1ps
module test_mcu_program_sequencer
    import mps_pkg::*;
();
    logic            clk, rst_b;             // clock and reset
    logic            psel, penable, pwrite;  // apb controls
    logic [7:0]      paddr;                  // apb address
    logic [31:0]     pwdata, prdata, rd;     // apb data, last read
    logic            pready, pslverr, err;   // apb answer, last error
    logic [PC_W-1:0] pmem_addr;              // fetch address
    logic [15:0]     pmem_data;              // program word
    logic [5:0]      irq_src, irq_req;       // request lines
    logic            rc_mode, second_oscillator_pin; // rc mode, sync pin
    logic [1:0]      phase;                  // phase index
    int              mismatches, cmp_count, cycles; // counters
    mps_sequencer dut (.*);
    mps_pmem_model pm (.*);
    // 100 mhz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard
    initial
    begin
        cycles = 0;
        forever
        begin
            @(posedge clk);
            cycles++;
            if (cycles == 8000)
            begin
                mismatches++;
                conclude();
            end
        end
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one apb transfer, entered after an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask : do_reset
    // bounded wait for a fetch address
    task automatic wait_pc(input logic [PC_W-1:0] target, input int limit, input string what);
        int n = 0;
        while (pmem_addr !== target && n < limit)
        begin
            @(negedge clk);
            n++;
        end
        check(what, 32'(pmem_addr), 32'(target));
        @(posedge clk);
    endtask : wait_pc
    // reset values and unmapped offset
    task automatic test_regs();
        do_reset();
        apb(1'b0, OFS_STATUS, 32'h0);
        check("pc after reset", rd, {19'h0, VEC_RESET});
        apb(1'b0, OFS_ACC, 32'h0);
        check("acc after reset", rd, {20'h0, RST_FLAGS, RST_ACC});
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        $display("test_regs done");
    endtask : test_regs
    // alu chain: {op, operand, result}
    task automatic test_alu();
        logic [19:0] tbl [19] = '{20'hf3c3c, 20'h50f0c, 20'h6505c, 20'h7ffa3, 20'h8a35c,
            20'hd5c5d, 20'he5d5c, 20'h95cb8, 20'hbb85c, 20'hf0808, 20'h00810, 20'h40016,
            20'hfffff, 20'h00100, 20'h11011, 20'h20110, 20'h3010f, 20'ha0f1f, 20'hc1f0f};
        do_reset();
        foreach (tbl[i])
        begin
            apb(1'b1, OFS_ALU, {1'b1, 19'h0, tbl[i][19:8]});
            apb(1'b0, OFS_ACC, 32'h0);
            check("alu result", {24'h0, rd[7:0]}, {24'h0, tbl[i][7:0]});
            if (i == 13)
                check("carry and zero", {30'h0, rd[10], rd[8]}, 32'h3);
        end
        $display("test_alu done");
    endtask : test_alu
    // branch kinds and fetch order
    task automatic test_flow();
        logic [PC_W-1:0] exp_tr [12] = '{13'h001, 13'h002, 13'h120, 13'h121, 13'h040, 13'h041,
            13'h121, 13'h122, 13'h123, 13'h124, 13'h123, 13'h124};
        logic [PC_W-1:0] last;
        int n = 0;
        do_reset();
        pm.mem[13'h001] = 16'h2120; // jump
        pm.mem[13'h120] = 16'h4040; // call
        pm.mem[13'h040] = 16'h6000; // return
        pm.mem[13'h121] = 16'ha080; // skip: 80+80 is zero
        pm.mem[13'h122] = 16'h2000; // skipped
        pm.mem[13'h123] = 16'h2123; // spin
        pm.mem[13'h180] = 16'h2180; // pcl landing
        apb(1'b1, OFS_ALU, {1'b1, 19'h0, 4'hf, 8'h80});
        rc_mode <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h1);
        last = VEC_RESET;
        for (int c = 0; c < 120 && n < 12; c++)
        begin
            @(negedge clk);
            if (pmem_addr !== last)
            begin
                check("fetch order", 32'(pmem_addr), 32'(exp_tr[n]));
                last = pmem_addr;
                n++;
            end
        end
        check("fetch count", 32'(n), 32'd12);
        @(posedge clk);
        apb(1'b1, OFS_PCLOW, 32'h80);
        wait_pc(13'h180, 40, "page-local jump");
        $display("test_flow done");
    endtask : test_flow
    // each source reaches its own vector
    task automatic test_vectors();
        logic [PC_W-1:0] vec;
        for (int i = 0; i < 6; i++)
        begin
            vec = 13'(VEC_EXT + VEC_STEP * i);
            do_reset();
            pm.mem[13'h000] = 16'h2000;
            pm.mem[vec] = {3'h1, vec};
            apb(1'b1, OFS_IRQ, 32'h80 | (32'h1 << i));
            apb(1'b1, OFS_CTRL, 32'h1);
            irq_req <= 6'(6'h1 << i);
            wait_pc(vec, 150, "interrupt vector");
            irq_req <= 6'h0;
        end
        $display("test_vectors done");
    endtask : test_vectors
    // full stack holds an interrupt
    task automatic test_stack();
        int hits = 0;
        do_reset();
        pm.mem[13'h000] = 16'h2200;
        for (int k = 0; k < 8; k++)
            pm.mem[13'h200 + k] = 16'(16'h4201 + k);
        pm.mem[13'h208] = 16'h2208;
        apb(1'b1, OFS_IRQ, 32'h81);
        apb(1'b1, OFS_CTRL, 32'h1);
        wait_pc(13'h208, 200, "stack filled");
        irq_req <= 6'h1;
        repeat (120)
        begin
            @(negedge clk);
            if (pmem_addr === VEC_EXT)
                hits++;
        end
        check("held while full", 32'(hits), 32'd0);
        @(posedge clk);
        apb(1'b0, OFS_IRQ, 32'h0);
        check("flag latched", {31'h0, rd[8]}, 32'h1);
        pm.mem[13'h208] = 16'h6000;
        wait_pc(VEC_EXT, 60, "served after return");
        irq_req <= 6'h0;
        $display("test_stack done");
    endtask : test_stack
    // main sequence
    initial
    begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, irq_req, rc_mode} = '0;
        {mismatches, cmp_count} = '0;
        @(posedge clk);
        test_regs();
        test_alu();
        test_flow();
        test_vectors();
        test_stack();
        conclude();
    end
endmodule : test_mcu_program_sequencer
